// ### include/stg_map.svh
// Constants for the sensor timing generator: APB offsets, fields, resets.
// Assumes a 32-bit APB with word-aligned registers.
`ifndef STG_MAP_SVH
`define STG_MAP_SVH
// -----------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------
`define STG_OFF_CTRL      12'h000
`define STG_OFF_CFG       12'h004
`define STG_OFF_LINELEN   12'h008
`define STG_OFF_STATUS    12'h00C
`define STG_OFF_LEN_BASE  12'h100
`define STG_OFF_LVL_BASE  12'h200
`define STG_OFF_ONOFF     12'h300
`define STG_OFF_INV       12'h310
`define STG_OFF_POL       12'h314
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define STG_CTRL_LOCK     0
`define STG_CTRL_MASTER   1
`define STG_CFG_NINT_LO   0
`define STG_CFG_SMUL_LO   2
`define STG_CFG_PMUL_LO   4
`define STG_CFG_SH_MODE   6
`define STG_CFG_PHASE_LO  7
// -----------------------------------------------------------------
// Sizes and reset values
// -----------------------------------------------------------------
`define STG_NUM_STATES    31
`define STG_NUM_OUT       8
`define STG_NUM_TG        4
`define STG_LINELEN_RST   16'h0100
`define STG_CTRL_RST      32'h0000_0002
`define STG_UNMAPPED_DATA 32'h0000_0000
`endif

// ### include/stg_pkg.sv
// Types for the sensor timing generator.
// Assumes stg_map.svh is on the include path.
package stg_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_XFER  = 3'b010,
      ST_PIXEL = 3'b100
   } seq_state_t;
endpackage

// ### rtl/sensor_timing_generator.sv
// Sensor timing generator: transfer-interval state sequencer, pixel portion,
// low-speed transfer gate ON/OFF, per-line inversion, APB register file.
// Assumes one 125 MHz clock; one clock is one pixel period; inputs synchronous.
//
// Chosen here: the APB register port and the placing of the registers.
`include "stg_map.svh"

// Operation
// - Up to 31 states, each drives a programmed level on every output.
// - Each state lasts its base length, 1 to 255 pixel periods.
// - State multiplier 2x/4x/8x/16x scales all state lengths.
// - First zero-length state ends the transfer interval.
// - Glitchless switch between interval and pixel timing, both ways.
// - Up to 4 intervals share the 31 states in fixed partitions.
// - Level bit one means high; per-output polarity may invert it.
// - Pixel portion: shift, reset, clamp toggle fast; gates give slow levels.
// - Each transfer gate has 16-bit ON and OFF pixel toggle points.
// - ON/OFF order gives low pulse, high pulse, constant high or low.
// - Shared 1x/2x/4x multiplier scales ON/OFF points and line length; here the fourth setting of the field also gives 8x.
// - Per-line inversion bit per output, shift pairs share one bit; here pairs a and b share bit 6, pair c has bit 7.
// - Advance to next sequence line at end of each transfer interval.
// - Master-select bit: one master, zero slave.
// - In master mode lock bit starts scan; lines repeat while set.
// - Master line period is scaled states plus scaled line length.
// - In slave mode a trigger pulse starts each line.
// - Output control bits flag scan start, line start, pixel type.
// - Sample/hold: reference strobe takes clamp ref, signal strobe pixel.
// - Strobes lie within one of 4 selectable coarse phase clocks; the signal strobe here falls one clock later, in the next phase.
// - Every sensor clock output has its own polarity bit; here shift pairs a and b share polarity bit 6.
module sensor_timing_generator (
   input  wire logic        i_clk_sys,                 // System clock, 125 MHz
   input  wire logic        i_sys_rst,                 // Sync reset, active high
   input  wire logic        psel,                      // APB select
   input  wire logic        penable,                   // APB access phase
   input  wire logic        pwrite,                    // APB write
   input  wire logic [11:0] paddr,                     // APB byte address
   input  wire logic [31:0] pwdata,                    // APB write data
   output logic      [31:0] prdata,                    // APB read data
   output logic             pready,                    // APB ready
   output logic             pslverr,                   // APB error
   input  wire logic        i_external_line_trigger,   // Slave line pulse
   output logic      [3:0]  o_transfer_gate_out,       // Transfer gates
   output logic      [2:0]  o_shift_clock_pair,        // Pairs a, b, c
   output logic             o_reset_gate_out,          // Reset gate
   output logic             o_clamp_pulse_out,         // Clamp pulse
   output logic      [3:0]  o_coarse_phase_clock,      // Four coarse phases
   output logic             o_ref_strobe,              // Clamp ref sample strobe
   output logic             o_sig_strobe,              // Signal sample strobe
   output logic      [4:0]  o_ctrl_bits                // Scan/line/type flags
);
   import stg_pkg::*;

   localparam int NS = `STG_NUM_STATES;
   localparam int NO = `STG_NUM_OUT;
   localparam int NT = `STG_NUM_TG;

   // -----------------------------------------------------------------
   // Register file
   // -----------------------------------------------------------------
   logic [1:0]  ctrl_ff;                // lock, master
   logic [9:0]  cfg_ff;
   logic [15:0] linelen_ff;
   logic [7:0]  len_ff [NS];
   logic [NO-1:0] lvl_ff [NS];
   logic [15:0] on_ff  [NT];
   logic [15:0] off_ff [NT];
   logic [NO-1:0] inv_ff [4];
   logic [NO-1:0] pol_ff;

   wire       acc     = psel & penable;
   wire       wr_acc  = acc & pwrite;
   // Word index; table slots past 30 read as unmapped
   wire [9:0] widx    = paddr[11:2] & 10'h03F;
   wire       in_len  = (paddr[11:8] == 4'h1) && (paddr[7:2] < 6'(NS));
   wire       in_lvl  = (paddr[11:8] == 4'h2) && (paddr[7:2] < 6'(NS));
   wire       in_onof = (paddr[11:4] == 8'h30);
   wire       is_ctrl = (paddr == `STG_OFF_CTRL);
   wire       is_cfg  = (paddr == `STG_OFF_CFG);
   wire       is_llen = (paddr == `STG_OFF_LINELEN);
   wire       is_stat = (paddr == `STG_OFF_STATUS);
   wire       is_inv  = (paddr == `STG_OFF_INV);
   wire       is_pol  = (paddr == `STG_OFF_POL);
   wire       mapped  = in_len | in_lvl | in_onof | is_ctrl | is_cfg | is_llen
                        | is_stat | is_inv | is_pol;
   wire [4:0] sidx    = widx[4:0];
   wire [1:0] tidx    = paddr[3:2];

   wire       master  = ctrl_ff[`STG_CTRL_MASTER];
   wire       lock    = ctrl_ff[`STG_CTRL_LOCK];
   wire [1:0] nint    = cfg_ff[`STG_CFG_NINT_LO +: 2];
   wire [1:0] smul    = cfg_ff[`STG_CFG_SMUL_LO +: 2];
   wire [1:0] pmul    = cfg_ff[`STG_CFG_PMUL_LO +: 2];
   wire       sh_mode = cfg_ff[`STG_CFG_SH_MODE];
   wire [1:0] phsel   = cfg_ff[`STG_CFG_PHASE_LO +: 2];

   // Register writes take effect only on the APB access edge
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ctrl_ff    <= 2'(`STG_CTRL_RST);
         cfg_ff     <= 10'h000;
         linelen_ff <= `STG_LINELEN_RST;
         pol_ff     <= '0;
      end else if (wr_acc) begin
         if (is_ctrl) ctrl_ff    <= pwdata[1:0];
         if (is_cfg)  cfg_ff     <= pwdata[9:0];
         if (is_llen) linelen_ff <= pwdata[15:0];
         if (is_pol)  pol_ff     <= pwdata[NO-1:0];
      end
   end

   // Tables: lengths, levels, ON/OFF, inversion (reset to zero)
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         for (int k = 0; k < NS; k++) begin
            len_ff[k] <= 8'h00;
            lvl_ff[k] <= '0;
         end
         for (int k = 0; k < NT; k++) begin
            on_ff[k]  <= 16'h0000;
            off_ff[k] <= 16'h0000;
            inv_ff[k] <= '0;
         end
      end else if (wr_acc) begin
         if (in_len)  len_ff[sidx] <= pwdata[7:0];
         if (in_lvl)  lvl_ff[sidx] <= pwdata[NO-1:0];
         if (in_onof) begin
            on_ff[tidx]  <= pwdata[15:0];
            off_ff[tidx] <= pwdata[31:16];
         end
         if (is_inv) begin
            for (int k = 0; k < 4; k++) inv_ff[k] <= pwdata[8*k +: NO];
         end
      end
   end

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   seq_state_t  st_ff;
   logic [4:0]  sti_ff;          // current state index
   logic [11:0] scnt_ff;         // scaled state count
   logic [17:0] pcnt_ff;         // pixel counter within pixel portion
   logic [1:0]  line_ff;         // line within sequence
   logic        first_ff;        // first line after lock rose
   logic        lock_d_ff;

   // interval partitions, first and last state per line
   logic [4:0] p_first, p_last;
   always_comb begin
      p_first = 5'd0;
      p_last  = 5'd30;
      case (nint)
         2'd1: begin p_first = line_ff[0] ? 5'd15 : 5'd0;
                     p_last  = line_ff[0] ? 5'd30 : 5'd14; end
         2'd2: begin
            case (line_ff)
               2'd0:    begin p_first = 5'd0;  p_last = 5'd9;  end
               2'd1:    begin p_first = 5'd10; p_last = 5'd19; end
               default: begin p_first = 5'd20; p_last = 5'd30; end
            endcase
         end
         2'd3: begin
            case (line_ff)
               2'd0:    begin p_first = 5'd0;  p_last = 5'd6;  end
               2'd1:    begin p_first = 5'd7;  p_last = 5'd14; end
               2'd2:    begin p_first = 5'd15; p_last = 5'd22; end
               default: begin p_first = 5'd23; p_last = 5'd30; end
            endcase
         end
         default: begin p_first = 5'd0; p_last = 5'd30; end
      endcase
   end

   wire [11:0] slen_s   = {4'h0, len_ff[sti_ff]} << (3'd1 + 3'(smul));
   // zero length or partition end closes the interval
   wire        cur_zero = (len_ff[sti_ff] == 8'h00);
   wire        st_done  = (scnt_ff + 12'd1 >= slen_s);
   wire [4:0]  sti_nx   = sti_ff + 5'd1;
   // Clamp the look-ahead so the table is never read past its end
   wire [4:0]  sti_la   = (sti_ff == 5'(NS - 1)) ? sti_ff : sti_nx;
   wire        nx_end   = (sti_ff == p_last) || (len_ff[sti_la] == 8'h00);
   // scaled line length ends the pixel portion
   wire [17:0] llen_s   = {2'b00, linelen_ff} << pmul;
   wire        pix_end  = (pcnt_ff + 18'd1 >= llen_s);
   // Line count wraps after the last configured interval
   wire [1:0]  line_nx  = (line_ff >= nint) ? 2'd0 : line_ff + 2'd1;
   // Master runs only while lock holds
   wire        run_m    = master & lock;
   wire        start    = master ? run_m : i_external_line_trigger;

   // State machine, one pixel period per clock
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st_ff     <= ST_IDLE;
         sti_ff    <= 5'd0;
         scnt_ff   <= 12'h000;
         pcnt_ff   <= 18'h0_0000;
         line_ff   <= 2'd0;
         first_ff  <= 1'b0;
         lock_d_ff <= 1'b0;
      end else begin
         lock_d_ff <= lock;
         case (st_ff)
            ST_IDLE: begin
               // Master waits for lock, slave for a trigger
               line_ff <= 2'd0;
               if (start) begin
                  st_ff    <= ST_XFER;
                  sti_ff   <= 5'd0;
                  scnt_ff  <= 12'h000;
                  first_ff <= master & ~lock_d_ff;
               end
            end
            ST_XFER: begin
               scnt_ff <= scnt_ff + 12'd1;
               if (cur_zero || (st_done && nx_end)) begin
                  st_ff   <= ST_PIXEL;
                  pcnt_ff <= 18'h0_0000;
                  line_ff <= line_nx;
               end else if (st_done) begin
                  sti_ff  <= sti_nx;
                  scnt_ff <= 12'h000;
               end
            end
            ST_PIXEL: begin
               pcnt_ff <= pcnt_ff + 18'd1;
               // line ends on length or trigger
               if ((master && pix_end) || (!master && i_external_line_trigger)) begin
                  first_ff <= 1'b0;
                  if (master && !lock) begin
                     st_ff <= ST_IDLE;
                  end else begin
                     st_ff   <= ST_XFER;
                     sti_ff  <= p_first;
                     scnt_ff <= 12'h000;
                  end
               end else if (master && !lock) begin
                  // Lock cleared mid-line: park at once
                  st_ff <= ST_IDLE;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Output generation
   // -----------------------------------------------------------------
   // Inversion bits apply to the line being read out
   // line_ff already moved on, so step back one
   wire [1:0]    pl_line = (line_ff == 2'd0) ? nint : line_ff - 2'd1;
   wire [NO-1:0] inv_cur = inv_ff[pl_line];
   wire          pix_ph  = pcnt_ff[0];
   wire [15:0]   pix_num = 16'(pcnt_ff >> pmul);
   logic [NO-1:0] lvl_int;
   logic [NT-1:0] tg_slow;

   // ON/OFF window per transfer gate
   // Points compare against the scaled pixel number
   genvar g;
   generate
      for (g = 0; g < NT; g++) begin : g_tg
         wire after_on  = pix_num >= on_ff[g];
         wire after_off = pix_num >= off_ff[g];
         assign tg_slow[g] = (on_ff[g] <= off_ff[g]) ? (after_on & ~after_off)
                                                     : (after_on | ~after_off);
      end
   endgenerate

   // select interval levels or pixel timing
   always_comb begin
      lvl_int = '0;
      case (st_ff)
         ST_XFER:  lvl_int = lvl_ff[sti_ff];
         ST_PIXEL: lvl_int = {~pix_ph, ~pix_ph, {2{pix_ph}}, tg_slow} ^ inv_cur;
         default:  lvl_int = '0;
      endcase
   end

   wire [NO-1:0] pin_nx = lvl_int ^ pol_ff;

   logic [NO-1:0] pin_ff;
   logic [1:0]    ph_ff;
   logic [4:0]    cb_ff;
   logic          rstb_ff, sstb_ff;
   // four coarse phases of the pixel clock.
   // Phase output comes from the same count as the strobes,
   // so the reference strobe always lands inside the selected phase.
   wire [3:0] phase_nx = 4'b0001 << ph_ff;
   wire       sel_ph   = (ph_ff == phsel);

   // registered pins, so mode switch is glitch-free
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         pin_ff  <= '0;
         ph_ff   <= 2'd0;
         cb_ff   <= 5'h00;
         rstb_ff <= 1'b0;
         sstb_ff <= 1'b0;
      end else begin
         pin_ff <= pin_nx;
         ph_ff  <= ph_ff + 2'd1;
         // scan start, line start, pixel type
         // Flags lag the sequencer one clock, like the pins
         cb_ff  <= {st_ff == ST_XFER,
                    (first_ff && st_ff == ST_XFER) ? 4'hF
                    : (st_ff == ST_PIXEL) ? {2'b00, line_ff} + 4'h1 : 4'h0};
         // reference strobe in selected phase, sample/hold mode only.
         // Signal strobe trails the reference by one clock, so the
         // reference is held first wherever the line started.
         rstb_ff <= sh_mode & (st_ff == ST_PIXEL) & sel_ph;
         sstb_ff <= rstb_ff;
      end
   end

   logic [3:0] phase_ff;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) phase_ff <= 4'b0001;
      else           phase_ff <= phase_nx;
   end

   // Pin map: [3:0] gates, [4] reset, [5] clamp, [7:6] shift pairs
   assign o_transfer_gate_out  = pin_ff[3:0];
   assign o_reset_gate_out     = pin_ff[4];
   assign o_clamp_pulse_out    = pin_ff[5];
   assign o_shift_clock_pair   = {pin_ff[7], pin_ff[6], pin_ff[6]};
   assign o_coarse_phase_clock = phase_ff;
   assign o_ref_strobe         = rstb_ff;
   assign o_sig_strobe         = sstb_ff;
   assign o_ctrl_bits          = cb_ff;

   // -----------------------------------------------------------------
   // APB read path, single wait-free access phase
   // -----------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = `STG_UNMAPPED_DATA;
      if (is_ctrl)      rd_mux = {30'h0, ctrl_ff};
      else if (is_cfg)  rd_mux = {22'h0, cfg_ff};
      else if (is_llen) rd_mux = {16'h0, linelen_ff};
      // Status: line, state index, state code, first-line flag
      else if (is_stat) rd_mux = {21'h0, line_ff, sti_ff, 3'(st_ff), first_ff};
      else if (in_len)  rd_mux = {24'h0, len_ff[sidx]};
      else if (in_lvl)  rd_mux = {24'h0, lvl_ff[sidx]};
      else if (in_onof) rd_mux = {off_ff[tidx], on_ff[tidx]};
      else if (is_inv)  rd_mux = {inv_ff[3], inv_ff[2], inv_ff[1], inv_ff[0]};
      else if (is_pol)  rd_mux = {24'h0, pol_ff};
   end

   // Ready answers every setup cycle: one access clock,
   // read data taken from the setup-cycle address
   logic [31:0] prdata_ff;
   logic        pready_ff, pslverr_ff;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= psel & ~penable;
         pslverr_ff <= psel & ~penable & ~mapped;
         prdata_ff  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end
   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
endmodule

// ### tb/stg_asserts.sv
// Concurrent checks on the sensor timing generator ports.
// Assumes one clock domain and a synchronous active-high reset.
module stg_asserts (
   input wire logic       i_clk_sys,            // System clock
   input wire logic       i_sys_rst,            // Sync reset
   input wire logic       psel,                 // APB select
   input wire logic       penable,              // APB access phase
   input wire logic       pready,               // APB ready
   input wire logic       pslverr,              // APB error
   input wire logic [3:0] o_transfer_gate_out,  // Transfer gates
   input wire logic [2:0] o_shift_clock_pair,   // Shift pairs
   input wire logic [3:0] o_coarse_phase_clock, // Coarse phases
   input wire logic [4:0] o_ctrl_bits           // Control bits
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   AST_READY_NEXT: assert property (s_setup |=> s_access)
      else $error("no ready in the access cycle");
   AST_READY_QUAL: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   AST_ERR_QUAL: assert property (pslverr |-> pready)
      else $error("error without ready");
   // ----------------------------------------
   // Sensor side
   // ----------------------------------------
   AST_RESET_VAL: assert property (disable iff (1'b0) i_sys_rst |=>
      o_coarse_phase_clock == 4'b0001 && o_transfer_gate_out == 4'h0 && o_ctrl_bits == 5'h00)
      else $error("outputs not at reset values");
   AST_PHASE_ONEHOT: assert property ($onehot(o_coarse_phase_clock))
      else $error("coarse phase not one-hot");
   AST_LINE_FLAG: assert property (o_ctrl_bits[4] |-> o_ctrl_bits[3:0] inside {4'hF, 4'h0})
      else $error("bad flag code in interval");
   AST_PIXEL_TYPE: assert property (!o_ctrl_bits[4] |-> o_ctrl_bits[3:0] <= 4'h4)
      else $error("bad flag code in pixel part");
   AST_PAIR_SHARE: assert property (o_shift_clock_pair[0] == o_shift_clock_pair[1])
      else $error("pairs a and b differ");
   // Third pixel cycle on keeps clear of the boundary lag
   AST_PIXEL_TOGGLE: assert property ((!o_ctrl_bits[4] && o_ctrl_bits[3:0] != 4'h0) [*3]
      |-> $changed(o_shift_clock_pair[2])) else $error("pair c idle in pixel part");
   AST_STATE_MIN: assert property ($rose(o_ctrl_bits[4]) |=> o_ctrl_bits[4])
      else $error("interval shorter than two clocks");
endmodule

bind sensor_timing_generator stg_asserts chk_u (
   .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .o_transfer_gate_out(o_transfer_gate_out),
   .o_shift_clock_pair(o_shift_clock_pair), .o_coarse_phase_clock(o_coarse_phase_clock),
   .o_ctrl_bits(o_ctrl_bits)
);

// ### tb/stg_sensor_model.sv
// External line trigger source standing in for the scan controller.
// Assumes requests arrive as one-cycle pulses on the system clock.
module stg_sensor_model #(
   parameter int MIN_GAP = 16                // Minimum clocks between pulses
) (
   input  wire logic i_clk_sys,              // System clock
   input  wire logic i_sys_rst,              // Sync reset
   input  wire logic i_fire,                 // Request a trigger pulse
   output logic      o_external_line_trigger // One-cycle line pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   int gap_ff;
   // spacing of triggers
   // Requests that come too soon are dropped, never queued
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         gap_ff                  <= MIN_GAP;
         o_external_line_trigger <= 1'b0;
      end else begin
         o_external_line_trigger <= i_fire && gap_ff >= MIN_GAP;
         gap_ff <= (i_fire && gap_ff >= MIN_GAP) ? 0 : gap_ff + (gap_ff < MIN_GAP);
      end
   end
endmodule

// ### tb/sensor_timing_generator_bench.sv
// Self-checking bench for the sensor timing generator over APB.
// Assumes one clock of 8 ns and a trigger model on the line input.
`include "stg_map.svh"
module sensor_timing_generator_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, psel, penable, pwrite, fire, trig;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, rgate, clamp, rstb, sstb;
   logic [3:0]  gates, phase;
   logic [2:0]  pairs;
   logic [4:0]  cbits;
   int          err_count, samples_checked;

   sensor_timing_generator dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .i_external_line_trigger(trig),
      .o_transfer_gate_out(gates), .o_shift_clock_pair(pairs), .o_reset_gate_out(rgate),
      .o_clamp_pulse_out(clamp), .o_coarse_phase_clock(phase), .o_ref_strobe(rstb),
      .o_sig_strobe(sstb), .o_ctrl_bits(cbits));
   stg_sensor_model model_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_fire(fire),
      .o_external_line_trigger(trig));

   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until ready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      if (pready !== 1'b1) err_count++;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r; logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic wait_rise;
      int n;
      n = 0;
      while (cbits[4] !== 1'b1 && n < 500) begin @(posedge clk); n++; end
      if (n >= 500) err_count++;
   endtask
   task automatic start(input logic [31:0] cfg);
      wr(`STG_OFF_CFG, cfg);
      wr(`STG_OFF_CTRL, 32'h0000_0003);
      wait_rise;
   endtask
   // Lock cleared: sequencer parks in idle at once in the pixel portion, after the interval otherwise
   task automatic stop;
      logic [31:0] r; logic e; int n;
      wr(`STG_OFF_CTRL, 32'h0000_0002);
      n = 0;
      do begin apb(1'b0, `STG_OFF_STATUS, 0, r, e); n++; end
      while (r[3:1] !== 3'b001 && n < 200);
      if (n >= 200) err_count++;
   endtask
   // One line from a rising interval flag: interval, pixel, gate 0 high count
   task automatic measure(output int hi, output int lo, output int g);
      hi = 0; lo = 0; g = 0;
      while (cbits[4] === 1'b1 && hi < 2000) begin
         g += (gates[0] === 1'b1); @(posedge clk); hi++;
      end
      while (cbits[4] === 1'b0 && lo < 2000) begin
         g += (gates[0] === 1'b1); @(posedge clk); lo++;
      end
   endtask
   task automatic setup_states(input logic [31:0] l0, input logic [31:0] l1);
      wr(`STG_OFF_LEN_BASE, l0);
      wr(`STG_OFF_LEN_BASE + 12'h004, l1);
      wr(`STG_OFF_LEN_BASE + 12'h008, 0);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      logic [31:0] r; logic e;
      check(phase, 4'b0001);
      apb(1'b0, `STG_OFF_CTRL, 0, r, e);
      check(r, `STG_CTRL_RST);
      apb(1'b0, `STG_OFF_LINELEN, 0, r, e);
      check(r, `STG_LINELEN_RST);
      apb(1'b0, 12'hFFC, 0, r, e);
      check(e, 1'b1);
      check(r, `STG_UNMAPPED_DATA);
   endtask
   task automatic t_scale;
      int hi, lo, g;
      setup_states(3, 2);
      wr(`STG_OFF_LINELEN, 5);
      for (int m = 0; m < 4; m++) begin
         start((m << 2) | ((m % 3) << 4));
         measure(hi, lo, g);
         check(hi, 5 << (m + 1));
         check(lo, 5 << (m % 3));
         check(hi + lo, (5 << (m + 1)) + (5 << (m % 3)));
         stop;
      end
   endtask
   task automatic t_level;
      wr(`STG_OFF_LVL_BASE, 32'h0000_0005);
      start(0);
      repeat (3) @(posedge clk);
      check(gates, 4'h5);
      stop;
      wr(`STG_OFF_POL, 32'h0000_0001);
      start(0);
      repeat (3) @(posedge clk);
      check(gates, 4'h4);
      stop;
      wr(`STG_OFF_POL, 0);
      wr(`STG_OFF_LVL_BASE, 0);
   endtask
   task automatic t_onoff;
      int hi, lo, g;
      int tbl[3][3] = '{'{2, 6, 4}, '{6, 2, 12}, '{5, 5, 0}};
      wr(`STG_OFF_LINELEN, 16);
      for (int i = 0; i < 3; i++) begin
         wr(`STG_OFF_ONOFF, (tbl[i][1] << 16) | tbl[i][0]);
         start(0);
         measure(hi, lo, g);
         check(g, tbl[i][2]);
         stop;
      end
      wr(`STG_OFF_ONOFF, 0);
   endtask
   task automatic t_slave;
      int n;
      wr(`STG_OFF_CTRL, 0);
      repeat (30) @(posedge clk);
      check(cbits[4], 1'b0);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      n = 0;
      while (cbits[4] !== 1'b1 && n < 8) begin @(posedge clk); n++; end
      check(n < 6, 1'b1);
      stop;
   endtask
   task automatic t_multi;
      int hi, lo, g;
      setup_states(2, 0);
      wr(`STG_OFF_LEN_BASE + 12'h03C, 4);
      wr(`STG_OFF_LEN_BASE + 12'h040, 0);
      start(1);
      measure(hi, lo, g);
      check(hi, 4);
      measure(hi, lo, g);
      check(hi, 8);
      measure(hi, lo, g);
      check(hi, 4);
      stop;
   endtask

   // First line in sample/hold mode with reset and clamp inverted
   task automatic t_pixel;
      int n;
      wr(`STG_OFF_INV, 32'h0000_0030);
      start(32'h0000_01C0);
      check(cbits, 5'h1F);
      n = 0;
      while (cbits[4] === 1'b1 && n < 99) begin @(posedge clk); n++; end
      check(cbits, 5'h01);
      check({clamp, rgate, pairs}, 5'h1F);
      @(posedge clk);
      check({clamp, rgate, pairs}, 5'h00);
      n = 0;
      while (rstb !== 1'b1 && n < 8) begin @(posedge clk); n++; end
      check({rstb, phase}, 5'h18);
      @(posedge clk);
      check({sstb, rstb}, 2'h2);
      stop;
   endtask

   task automatic end_of_test;
      if (err_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Clock, reset and sequence
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; fire = 1'b0;
      paddr = 12'h000; pwdata = 32'h0000_0000; err_count = 0; samples_checked = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_scale;
      t_level;
      t_onoff;
      t_slave;
      t_multi;
      t_pixel;
      end_of_test;
   end
   // Whole run needs well under this many clocks
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      end_of_test;
   end
endmodule
